// >>> hw/flash_access_pkg.sv
// Constants, field layout and register map of the flash access block.
// Summary of operation
// [RULE1] The two lowest sectors are each exactly 4 Kbytes.
// [RULE2] Boot sector zero sits at F000h-FFFFh with the vectors.
// [RULE3] A 4K array has one sector, 8K has two, anything larger has three.
// [RULE4] A sector erase clears that sector only and leaves the others intact.
// [RULE5] The whole array can be erased at once and programmed byte by byte.
// [RULE6] Read-out protection blocks external reads and all flash writes.
// [RULE7] Unprotect first erases all of the array, then allows reprogramming.
// [RULE8] One option bit switches read-out protection on and off.
// [RULE9] The low-voltage detector is off whenever read-out protection is on.
// [RULE10] Tool and board modes may program or erase all sectors and options.
// [RULE11] Application mode refuses program and erase of boot sector zero.
// [RULE12] Board programming needs communication mode switched on beforehand.
// [RULE13] An 8-bit control register, reset to 00h, governs program and erase.
package flash_access_pkg;

	// ************************************************************
	// Register indices; the bus byte address is four times the index.
	// ************************************************************
	localparam logic [5:0] REG_ADDR_IDX = 6'h00;
	localparam logic [5:0] REG_DATA_IDX = 6'h01;
	localparam logic [5:0] REG_OPTION_IDX = 6'h02;
	localparam logic [5:0] REG_MODE_IDX = 6'h03;
	localparam logic [5:0] REG_STATUS_IDX = 6'h04;
	localparam logic [5:0] REG_READ_IDX = 6'h05;
	localparam logic [5:0] REG_CTL_IDX = 6'h29;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int CTL_PROG_BIT = 0;
	localparam int CTL_ERASE_BIT = 1;
	localparam int CTL_MASS_BIT = 2;
	localparam int CTL_SEL_LSB = 3;
	localparam logic [7:0] CTL_GO_MASK = 8'h07;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam int OPT_PROTECT_BIT = 0;
	localparam int OPT_DETECT_BIT = 1;
	localparam int MODE_COMM_BIT = 2;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_REJECT_BIT = 1;
	localparam int ST_DONE_BIT = 2;
	localparam int ST_PROTECT_BIT = 3;
	localparam int ST_DETECT_BIT = 4;
	localparam int ST_UNPROT_BIT = 5;

	// ************************************************************
	// Array geometry
	// ************************************************************
	localparam int ADDR_SPACE = 65536;
	localparam int SECTOR_BYTES = 4096;
	localparam int SIZE_ONE_SECTOR = 4096;
	localparam int SIZE_TWO_SECTORS = 8192;
	localparam logic [15:0] SECTOR0_BASE = 16'hF000;
	localparam logic [15:0] SECTOR1_BASE = 16'hE000;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	typedef enum logic [1:0] {
		MODE_TOOL = 2'h0,
		MODE_BOARD = 2'h1,
		MODE_APP = 2'h2
	} prog_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SWEEP = 2'b01,
		ST_UNPROT = 2'b11
	} seq_state_t;

endpackage

// >>> hw/flash_array_mem.sv
// Byte-wide flash array storage with a registered read port.
`timescale 1ns/1ps
module flash_array_mem #(
	parameter int DEPTH = 32768,
	parameter int AW = 15
) (
	// Clock
	input wire logic clk_i,
	// Access port
	input wire logic we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);

	logic [7:0] cells [DEPTH];

	// Read returns the old byte on a write cycle; the new one follows next.
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			cells[addr_i] <= wdata_i;
		end
		rdata_o <= cells[addr_i];
	end

endmodule

// >>> hw/flash_sweep.sv
// Address walker that writes the erased value over a range of the array.
`timescale 1ns/1ps
module flash_sweep #(
	parameter int AW = 15
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Range request
	input wire logic start_i,
	input wire logic [AW-1:0] base_i,
	input wire logic [AW:0] count_i,
	// Array side
	output logic [AW-1:0] addr_o,
	output logic we_o,
	output logic done_o
);

	logic [AW:0] left;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			left <= '0;
			addr_o <= '0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				addr_o <= base_i;
				left <= count_i;
			end else if (left != '0) begin
				addr_o <= addr_o + AW'(1);
				left <= left - (AW+1)'(1);
				done_o <= (left == (AW+1)'(1));
			end
		end
	end

	assign we_o = (left != '0);

endmodule

// >>> hw/sector_flash_access_protect.sv
// Sectored flash access control with read-out protection on classic Wishbone.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
module sector_flash_access_protect #(
	parameter int FLASH_BYTES = 32768
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Device status
	output logic readout_protect_o,
	output logic low_voltage_detector_en_o,
	output logic busy_o
);
	import flash_access_pkg::*;

	// ************************************************************
	// Geometry
	// ************************************************************
	localparam int AW = $clog2(FLASH_BYTES);

	function automatic int num_sectors(input int bytes);
		if (bytes <= SIZE_ONE_SECTOR) begin
			return 1;
		end else if (bytes <= SIZE_TWO_SECTORS) begin
			return 2;
		end
		return 3;
	endfunction

	function automatic logic [1:0] sector_of(input logic [15:0] a);
		if (a >= SECTOR0_BASE) begin
			return 2'd0;
		end else if (a >= SECTOR1_BASE) begin
			return 2'd1;
		end
		return 2'd2;
	endfunction

	function automatic logic reg_hit(input logic [7:0] a,
		input logic [5:0] idx);
		return a == {idx, 2'b00};
	endfunction

	localparam logic [1:0] NSEC = 2'(num_sectors(FLASH_BYTES)); // [RULE3]
	localparam logic [15:0] FLASH_BASE = 16'(ADDR_SPACE - FLASH_BYTES);
	localparam logic [AW:0] FULL_N = (AW+1)'(FLASH_BYTES);
	localparam logic [AW:0] SEC_N = (AW+1)'(SECTOR_BYTES);
	localparam logic [AW:0] REST_N =
		(AW+1)'(FLASH_BYTES - 2 * SECTOR_BYTES);
	localparam logic [AW-1:0] S0_BASE = AW'(FLASH_BYTES - SECTOR_BYTES);
	localparam logic [AW-1:0] S1_BASE =
		AW'(FLASH_BYTES - 2 * SECTOR_BYTES);

	// ************************************************************
	// State
	// ************************************************************
	seq_state_t state;
	seq_state_t next_state;
	prog_mode_t mode;
	logic [15:0] flash_addr;
	logic [7:0] wdata;
	logic [7:0] flash_program_control_status;
	logic readout_protect_option_bit;
	logic detector_request;
	logic external_comm_mode;
	logic reject;
	logic done;
	logic ack;
	logic [31:0] dat;
	logic [AW-1:0] range_lo;
	logic [AW:0] range_n;
	logic [AW-1:0] sweep_addr;
	logic sweep_we;
	logic sweep_done;
	logic [7:0] mem_q;

	// ************************************************************
	// Bus decode
	// ************************************************************
	wire acc = wb_cyc_i & wb_stb_i;
	wire wr = acc & wb_we_i & ack;
	wire rd_take = acc & ~wb_we_i & ~ack;
	wire lane0 = wb_sel_i[0];
	wire lane1 = wb_sel_i[1];
	wire hit_addr = reg_hit(wb_adr_i, REG_ADDR_IDX);
	wire hit_data = reg_hit(wb_adr_i, REG_DATA_IDX);
	wire hit_opt = reg_hit(wb_adr_i, REG_OPTION_IDX);
	wire hit_mode = reg_hit(wb_adr_i, REG_MODE_IDX);
	wire hit_st = reg_hit(wb_adr_i, REG_STATUS_IDX);
	wire hit_rd = reg_hit(wb_adr_i, REG_READ_IDX);
	wire hit_ctl = reg_hit(wb_adr_i, REG_CTL_IDX);

	// ************************************************************
	// Permission checks
	// ************************************************************
	wire idle = (state == ST_IDLE);
	wire app_mode = (mode == MODE_APP);
	// Board-level work is only legal once the outside party has switched
	// the part into its communication mode.
	wire mode_ok = (mode == MODE_TOOL) | app_mode |
		((mode == MODE_BOARD) & external_comm_mode); // [RULE12] [RULE10]
	wire writable = idle & ~readout_protect_option_bit & mode_ok; // [RULE6]
	wire in_flash = (flash_addr >= FLASH_BASE);
	wire [1:0] prog_sec = sector_of(flash_addr);
	wire [1:0] sel_sec = wb_dat_i[CTL_SEL_LSB +: 2];

	wire ctl_wr = wr & hit_ctl & lane0;
	wire go_prog = ctl_wr & wb_dat_i[CTL_PROG_BIT];
	wire go_erase = ctl_wr & wb_dat_i[CTL_ERASE_BIT] & ~go_prog;
	wire go_mass = ctl_wr & wb_dat_i[CTL_MASS_BIT] & ~go_prog &
		~wb_dat_i[CTL_ERASE_BIT];

	wire prog_ok = writable & in_flash &
		~(app_mode & (prog_sec == 2'd0)); // [RULE11]
	wire erase_ok = writable & (sel_sec < NSEC) &
		~(app_mode & (sel_sec == 2'd0)); // [RULE11] [RULE3]
	wire mass_ok = writable & ~app_mode; // [RULE11]

	wire launch_prog = go_prog & prog_ok; // [RULE5]
	wire launch_erase = go_erase & erase_ok; // [RULE4]
	wire launch_mass = go_mass & mass_ok; // [RULE5]

	// Option writes are closed to the running application.
	wire opt_wr = wr & hit_opt & lane0;
	wire opt_ok = idle & mode_ok & ~app_mode; // [RULE10]
	wire opt_new = wb_dat_i[OPT_PROTECT_BIT];
	wire unprot_start = opt_wr & opt_ok & readout_protect_option_bit &
		~opt_new; // [RULE7]

	wire reject_set = (go_prog & ~prog_ok) | (go_erase & ~erase_ok) |
		(go_mass & ~mass_ok) | (opt_wr & ~opt_ok);
	wire done_set = launch_prog | sweep_done;
	wire st_wr = wr & hit_st & lane0;

	// ************************************************************
	// Erase range selection
	// ************************************************************
	wire [AW-1:0] next_lo = launch_erase ?
		((sel_sec == 2'd0) ? S0_BASE :
		(sel_sec == 2'd1) ? S1_BASE : '0) : '0; // [RULE2] [RULE4]
	wire [AW:0] next_n = launch_erase ?
		((sel_sec == 2'd2) ? REST_N : SEC_N) : FULL_N; // [RULE1]
	wire sweep_start = launch_erase | launch_mass | unprot_start;

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (unprot_start) begin
					next_state = ST_UNPROT;
				end else if (launch_erase | launch_mass) begin
					next_state = ST_SWEEP;
				end
			end
			ST_SWEEP: begin
				if (sweep_done) begin
					next_state = ST_IDLE;
				end
			end
			ST_UNPROT: begin
				if (sweep_done) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			range_lo <= '0;
			range_n <= '0;
		end else begin
			state <= next_state;
			if (sweep_start) begin
				range_lo <= next_lo;
				range_n <= next_n;
			end
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_addr <= 16'h0000;
			wdata <= 8'h00;
			mode <= MODE_TOOL;
			external_comm_mode <= 1'b0;
			flash_program_control_status <= CTL_RESET; // [RULE13]
		end else begin
			if (wr & hit_addr & lane0) begin
				flash_addr[7:0] <= wb_dat_i[7:0];
			end
			if (wr & hit_addr & lane1) begin
				flash_addr[15:8] <= wb_dat_i[15:8];
			end
			if (wr & hit_data & lane0) begin
				wdata <= wb_dat_i[7:0];
			end
			if (wr & hit_mode & lane0) begin
				mode <= prog_mode_t'(wb_dat_i[1:0]);
				external_comm_mode <= wb_dat_i[MODE_COMM_BIT];
			end
			// Go bits act once and read back as zero.
			if (ctl_wr) begin
				flash_program_control_status <=
					wb_dat_i[7:0] & ~CTL_GO_MASK; // [RULE13]
			end
		end
	end

	// The protect bit holds during the automatic erase so that nothing can
	// be read out of a half-erased array.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			readout_protect_option_bit <= 1'b0;
			detector_request <= 1'b0;
		end else begin
			if (state == ST_UNPROT && sweep_done) begin
				readout_protect_option_bit <= 1'b0; // [RULE7]
			end else if (opt_wr & opt_ok & opt_new) begin
				readout_protect_option_bit <= 1'b1; // [RULE8]
			end
			if (opt_wr & opt_ok) begin
				detector_request <= wb_dat_i[OPT_DETECT_BIT];
			end
		end
	end

	// Sticky flags: a new event beats a clear in the same cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reject <= 1'b0;
			done <= 1'b0;
		end else begin
			reject <= reject_set |
				(reject & ~(st_wr & wb_dat_i[ST_REJECT_BIT]));
			done <= done_set |
				(done & ~(st_wr & wb_dat_i[ST_DONE_BIT]));
		end
	end

	// ************************************************************
	// Array path
	// ************************************************************
	wire mem_we = sweep_we | launch_prog;
	wire [AW-1:0] mem_addr = sweep_we ? sweep_addr : flash_addr[AW-1:0];
	wire [7:0] mem_wdata = sweep_we ? ERASED_BYTE : wdata;

	flash_sweep #(
		.AW(AW)
	) u_sweep (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(sweep_start),
		.base_i(next_lo),
		.count_i(next_n),
		.addr_o(sweep_addr),
		.we_o(sweep_we),
		.done_o(sweep_done)
	);

	flash_array_mem #(
		.DEPTH(FLASH_BYTES),
		.AW(AW)
	) u_mem (
		.clk_i(clk_i),
		.we_i(mem_we),
		.addr_i(mem_addr),
		.wdata_i(mem_wdata),
		.rdata_o(mem_q)
	);

	// ************************************************************
	// Read data and acknowledge
	// ************************************************************
	// Only code running on the part may read a protected array.
	wire rd_blocked = (readout_protect_option_bit & ~app_mode) |
		~idle | ~in_flash; // [RULE6]
	wire [7:0] status = {2'b00, (state == ST_UNPROT),
		low_voltage_detector_en_o, readout_protect_option_bit, done,
		reject, ~idle};
	wire [7:0] opt_rd = {6'h00, detector_request,
		readout_protect_option_bit};
	wire [7:0] mode_rd = {5'h00, external_comm_mode, mode};
	wire [31:0] rd_mux = hit_addr ? {16'h0000, flash_addr} :
		hit_data ? {24'h000000, wdata} :
		hit_opt ? {24'h000000, opt_rd} :
		hit_mode ? {24'h000000, mode_rd} :
		hit_st ? {24'h000000, status} :
		hit_rd ? {24'h000000, rd_blocked ? 8'h00 : mem_q} :
		hit_ctl ? {24'h000000, flash_program_control_status} :
		32'h00000000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
			dat <= 32'h00000000;
		end else begin
			ack <= acc & ~ack;
			if (rd_take) begin
				dat <= rd_mux;
			end
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = dat;
	assign readout_protect_o = readout_protect_option_bit;
	assign low_voltage_detector_en_o = detector_request &
		~readout_protect_option_bit; // [RULE9]
	assign busy_o = ~idle;

	// ************************************************************
	// Checks
	// ************************************************************
	sector_size_a: assert property (@(posedge clk_i) // [RULE1]
		disable iff (rst_i) launch_erase && sel_sec != 2'd2 |=> range_n == SEC_N)
		else $error("low sector erase size is not one sector");
	boot_base_a: assert property (@(posedge clk_i) // [RULE2]
		disable iff (rst_i) launch_erase && sel_sec == 2'd0 |=> range_lo == S0_BASE)
		else $error("boot sector erase starts at the wrong offset");
	missing_sector_a: assert property (@(posedge clk_i) // [RULE3]
		disable iff (rst_i) go_erase && sel_sec >= NSEC |-> !launch_erase ##1 reject)
		else $error("erase of an absent sector was not refused");
	erase_range_a: assert property (@(posedge clk_i) // [RULE4]
		disable iff (rst_i) sweep_we |-> (AW+1)'(sweep_addr - range_lo) < range_n)
		else $error("erase wrote outside the chosen range");
	mass_erase_a: assert property (@(posedge clk_i) // [RULE5]
		disable iff (rst_i) launch_mass |=> state == ST_SWEEP
		&& range_n == FULL_N && range_lo == '0)
		else $error("mass erase did not cover the whole array");
	protect_block_a: assert property (@(posedge clk_i) // [RULE6]
		disable iff (rst_i) rd_take && hit_rd && readout_protect_option_bit
		&& !app_mode |=> wb_dat_o == 32'h00000000 && wb_ack_o)
		else $error("protected array leaked to an external read");
	protect_write_a: assert property (@(posedge clk_i) // [RULE6]
		disable iff (rst_i) readout_protect_o && go_prog |-> !launch_prog ##1 reject)
		else $error("program went through under protection");
	unprot_erase_a: assert property (@(posedge clk_i) // [RULE7]
		disable iff (rst_i) unprot_start |=> state == ST_UNPROT
		&& readout_protect_o && range_n == FULL_N)
		else $error("protection removed without a full erase");
	unprot_end_a: assert property (@(posedge clk_i) // [RULE7]
		disable iff (rst_i) state == ST_UNPROT && sweep_done
		|=> !readout_protect_o && state == ST_IDLE)
		else $error("protection stayed after the automatic erase");
	protect_set_a: assert property (@(posedge clk_i) // [RULE8]
		disable iff (rst_i) opt_wr && opt_ok && opt_new |=> readout_protect_o)
		else $error("option bit did not turn protection on");
	detector_off_a: assert property (@(posedge clk_i) // [RULE9]
		disable iff (rst_i) readout_protect_o |-> !low_voltage_detector_en_o)
		else $error("voltage detector on under protection");
	tool_boot_a: assert property (@(posedge clk_i) // [RULE10]
		disable iff (rst_i) go_erase && mode == MODE_TOOL && writable
		&& sel_sec == 2'd0 |=> state == ST_SWEEP)
		else $error("tool mode could not erase the boot sector");
	app_boot_a: assert property (@(posedge clk_i) // [RULE11]
		disable iff (rst_i) go_prog && app_mode && prog_sec == 2'd0
		|-> !launch_prog ##1 reject)
		else $error("application changed the boot sector");
	comm_needed_a: assert property (@(posedge clk_i) // [RULE12]
		disable iff (rst_i) go_prog && mode == MODE_BOARD
		&& !external_comm_mode |-> !launch_prog)
		else $error("board programming without communication mode");
	ctl_reset_a: assert property (@(posedge clk_i) // [RULE13]
		rst_i |=> flash_program_control_status == CTL_RESET)
		else $error("control register not zero after reset");

endmodule

// >>> sim/prog_tool_model.sv
// Programming tool model that drives the Wishbone register bus.
`timescale 1ns/1ps
module prog_tool_model (
	// Clock
	input wire logic clk_i,
	// Wishbone master
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o,
	input wire logic ack_i,
	input wire logic [31:0] dat_i
);
	import flash_access_pkg::*;

	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end

	// The request stays up until ack is sampled; only the bench watchdog
	// can end a wait, so a silent slave shows up as a timeout.
	task automatic xfer(input logic w, input logic [5:0] idx,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= {idx, 2'b00};
		sel_o <= (idx == REG_ADDR_IDX) ? 4'h3 : 4'h1;
		dat_o <= d;
		do begin
			@(posedge clk_i);
		end while (ack_i !== 1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, idx, d, q);
	endtask

	task automatic rd(input logic [5:0] idx, output logic [31:0] q);
		xfer(1'b0, idx, 32'h0, q);
	endtask

	// Board-level mode is entered here with the comm bit set at once.
	task automatic board_enter();
		wr(REG_MODE_IDX, 32'h5);
	endtask
endmodule

// >>> sim/sector_flash_access_protect_tb_top.sv
// Self-checking bench of the sectored flash access block.
`timescale 1ns/1ps
module sector_flash_access_protect_tb_top;
	import flash_access_pkg::*;

	typedef struct packed {
		logic [15:0] a;
		logic [7:0] d;
		logic [2:0] m;
		logic [7:0] e;
		logic r;
	} row_t;

	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc, stb, we, ack, prot, det_en, busy;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat_w, dat_r, q;
	int fails = 0;
	int samples_checked = 0;
	// Address, data, mode with comm bit, read-back value, refused.
	row_t rows [7] = '{
		'{16'hF000, 8'h5A, 3'h0, 8'h5A, 1'b0},
		'{16'hFFFF, 8'hA5, 3'h0, 8'hA5, 1'b0},
		'{16'hE000, 8'h3C, 3'h5, 8'h3C, 1'b0},
		'{16'hE010, 8'hC3, 3'h2, 8'hC3, 1'b0},
		'{16'hF010, 8'h11, 3'h2, 8'hFF, 1'b1},
		'{16'hF020, 8'h22, 3'h1, 8'hFF, 1'b1},
		'{16'h1000, 8'h33, 3'h0, 8'h00, 1'b1}};

	always #20 clk_i = ~clk_i;

	sector_flash_access_protect #(.FLASH_BYTES(8192)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
		.wb_dat_o(dat_r), .wb_ack_o(ack), .readout_protect_o(prot),
		.low_voltage_detector_en_o(det_en), .busy_o(busy));

	prog_tool_model TOOL (
		.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
		.sel_o(sel), .dat_o(dat_w), .ack_i(ack), .dat_i(dat_r));

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic read_at(input logic [15:0] a, input logic [7:0] e);
		TOOL.wr(REG_ADDR_IDX, {16'h0, a});
		TOOL.rd(REG_READ_IDX, q);
		chk("array byte", {24'h0, e}, q);
	endtask

	task automatic reject_is(input logic r);
		TOOL.rd(REG_STATUS_IDX, q);
		chk("reject", {31'h0, r}, {31'h0, q[ST_REJECT_BIT]});
		TOOL.wr(REG_STATUS_IDX, 32'h6);
	endtask

	// Lets the edge of the last write land before outputs are looked at.
	task automatic erase_run();
		repeat (2) @(posedge clk_i);
		chk("busy start", 32'h1, {31'h0, busy});
		while (busy !== 1'b0) @(posedge clk_i);
	endtask

	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk_i);
		fails++;
		$display("FAIL watchdog expected done seen hang");
		summarize();
	end

	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		TOOL.rd(REG_CTL_IDX, q);
		chk("ctl reset", 32'h0, q);
		TOOL.wr(REG_CTL_IDX, 32'hF8);
		TOOL.rd(REG_CTL_IDX, q);
		chk("ctl rw", 32'hF8, q);
		TOOL.wr(REG_CTL_IDX, 32'h4);
		erase_run();
		$display("mass erase done");
		foreach (rows[i]) begin
			TOOL.wr(REG_STATUS_IDX, 32'h6);
			TOOL.wr(REG_MODE_IDX, {29'h0, rows[i].m});
			TOOL.wr(REG_ADDR_IDX, {16'h0, rows[i].a});
			TOOL.wr(REG_DATA_IDX, {24'h0, rows[i].d});
			TOOL.wr(REG_CTL_IDX, 32'h1);
			reject_is(rows[i].r);
			TOOL.wr(REG_MODE_IDX, 32'h0);
			read_at(rows[i].a, rows[i].e);
			$display("row %0d done", i);
		end
		TOOL.wr(REG_CTL_IDX, 32'h0A);
		erase_run();
		read_at(16'hE010, 8'hFF);
		read_at(16'hF000, 8'h5A);
		TOOL.wr(REG_CTL_IDX, 32'h12);
		reject_is(1'b1);
		TOOL.wr(REG_MODE_IDX, 32'h2);
		TOOL.wr(REG_CTL_IDX, 32'h02);
		reject_is(1'b1);
		TOOL.wr(REG_MODE_IDX, 32'h0);
		read_at(16'hF000, 8'h5A);
		$display("sector erase done");
		TOOL.wr(REG_OPTION_IDX, 32'h2);
		@(posedge clk_i);
		chk("detector on", 32'h1, {31'h0, det_en});
		TOOL.wr(REG_OPTION_IDX, 32'h3);
		@(posedge clk_i);
		chk("protect", 32'h1, {31'h0, prot});
		chk("detector off", 32'h0, {31'h0, det_en});
		read_at(16'hF000, 8'h00);
		TOOL.wr(REG_CTL_IDX, 32'h1);
		reject_is(1'b1);
		TOOL.board_enter();
		TOOL.wr(REG_OPTION_IDX, 32'h2);
		erase_run();
		@(posedge clk_i);
		chk("unprotect", 32'h0, {31'h0, prot});
		chk("detector back", 32'h1, {31'h0, det_en});
		TOOL.wr(REG_MODE_IDX, 32'h0);
		read_at(16'hF000, 8'hFF);
		read_at(16'hFFFF, 8'hFF);
		$display("protection done");
		TOOL.wr(REG_ADDR_IDX, 32'hF000);
		TOOL.wr(REG_DATA_IDX, 32'h77);
		TOOL.wr(REG_CTL_IDX, 32'h1);
		read_at(16'hF000, 8'h77);
		TOOL.wr(REG_STATUS_IDX, 32'h6);
		TOOL.wr(REG_CTL_IDX, 32'h02);
		erase_run();
		TOOL.rd(REG_STATUS_IDX, q);
		chk("erase done", 32'h1, {31'h0, q[ST_DONE_BIT]});
		read_at(16'hF000, 8'hFF);
		$display("boot erase done");
		TOOL.rd(6'h10, q);
		chk("unmapped", 32'h0, q);
		TOOL.wr(REG_CTL_IDX, 32'hF8);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		TOOL.rd(REG_CTL_IDX, q);
		chk("ctl rereset", 32'h0, q);
		chk("detector reset", 32'h0, {31'h0, det_en});
		$display("reset done");
		summarize();
	end
endmodule
